// ===== hdl/urw_pkg.sv
// urw_pkg: constants and types of the serial port wakeup, loop and irq block
// assumes one 40 MHz bus clock and a 32-bit APB slave port
package urw_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned BAUD_DEF    = 115_200;
  localparam int unsigned BIT_CYC_DEF = CLK_HZ / BAUD_DEF;

  // register byte offsets
  localparam logic [7:0] A_CTRL1 = 8'h00;
  localparam logic [7:0] A_CTRL2 = 8'h04;
  localparam logic [7:0] A_STAT1 = 8'h08;
  localparam logic [7:0] A_STAT2 = 8'h0C;
  localparam logic [7:0] A_DATA  = 8'h10;

  // port_control_one fields
  localparam int C1_LONG = 0;
  localparam int C1_ILT  = 1;
  localparam int C1_WAKE = 2;
  localparam int C1_RX_SOURCE_SEL = 3;
  localparam int C1_LOOP = 4;
  // port_control_two fields
  localparam int C2_STBY = 0;
  localparam int C2_RXEN = 1;
  localparam int C2_TXEN = 2;
  localparam int C2_IDLE_IRQ_EN = 3;
  localparam int C2_RIE  = 4;
  localparam int C2_TX_COMPLETE_IRQ_EN = 5;
  localparam int C2_TIE  = 6;
  // status_one fields, low to high: overrun, idle, rx full, tx complete, tx empty
  localparam int S1_LSB = 3;
  localparam int S2_DIR = 1;

  // reset values
  localparam logic [4:0] CTRL1_RST = 5'h00;
  localparam logic [6:0] CTRL2_RST = 7'h00;
  localparam logic       TX_EMPTY_FLAG_RST  = 1'b1;
  localparam logic       TC_RST    = 1'b1;

  // consecutive ones that make an idle character
  localparam logic [3:0] IDLE_SHORT = 4'hA;
  localparam logic [3:0] IDLE_LONG  = 4'hB;
  // data bits per frame
  localparam logic [3:0] NBIT_SHORT = 4'h8;
  localparam logic [3:0] NBIT_LONG  = 4'h9;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} urw_rx_st_t;
endpackage

// ===== hdl/urw_rx_eng.sv
// urw_rx_eng: frame receiver and idle line counter
// assumes a synchronised, glitch filtered line from the controller
`timescale 1ns/1ps
`default_nettype none
module urw_rx_eng
  import urw_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller side
  urw_rx_if.eng    rx
);
  localparam int unsigned CW = $clog2(BIT_CYC);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF     = CW'(BIT_CYC / 2);

  urw_rx_st_t    st_q;
  logic [CW-1:0] tmr_q;
  logic [3:0]    bit_q;
  logic [8:0]    sh_q;
  logic [3:0]    ones_q;
  logic          line_q;
  logic          done_q;
  logic          msb_q;
  logic          hit_q;

  wire       tick   = tmr_q == BIT_LAST;
  wire       fall   = line_q & ~rx.line;
  wire [3:0] nbits  = rx.long_frame ? NBIT_LONG : NBIT_SHORT;
  wire [3:0] idle_n = rx.long_frame ? IDLE_LONG : IDLE_SHORT;
  wire       last   = bit_q == nbits - 4'h1;
  // counting from the stop bit restarts the run there
  wire       stop_rst = rx.idle_type & (st_q == RX_STOP);
  wire       one_inc  = rx.line & ~stop_rst & (ones_q != idle_n);
  wire       go_start = (st_q == RX_IDLE) & fall;

  assign rx.done     = done_q;
  assign rx.data     = rx.long_frame ? sh_q : {1'b0, sh_q[8:1]};
  assign rx.msb_mark = msb_q;
  assign rx.idle_lvl = rx.en & (ones_q == idle_n);
  assign rx.idle_hit = hit_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= '0;
      line_q <= 1'b1;
    end else begin
      line_q <= rx.line;
      tmr_q <= (go_start & rx.en) ? HALF : (tick ? '0 : tmr_q + 1'b1);
    end
  end

  // in idle the timer free-runs, so ones are counted at the bit rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ones_q <= 4'h0;
      hit_q <= 1'b0;
    end else begin
      hit_q <= rx.en & tick & one_inc & (ones_q == idle_n - 4'h1);
      if (!rx.en || (tick && (!rx.line || stop_rst))) begin
        ones_q <= 4'h0;
      end else if (tick && one_inc) begin
        ones_q <= ones_q + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= RX_IDLE;
      bit_q <= 4'h0;
      sh_q <= 9'h000;
      done_q <= 1'b0;
      msb_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      msb_q <= 1'b0;
      if (!rx.en) begin
        st_q <= RX_IDLE;
      end else begin
        case (st_q)
          RX_IDLE: begin
            if (fall) begin
              st_q <= RX_START;
            end
          end
          RX_START: begin
            if (tick) begin
              st_q <= rx.line ? RX_IDLE : RX_DATA;
              bit_q <= 4'h0;
            end
          end
          RX_DATA: begin
            if (tick) begin
              sh_q <= {rx.line, sh_q[8:1]};
              bit_q <= bit_q + 4'h1;
              msb_q <= last & rx.line;
              if (last) begin
                st_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (tick) begin
              done_q <= 1'b1;
              st_q <= RX_IDLE;
            end
          end
          default: st_q <= RX_IDLE;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_IDLE_COUNT: assert property (hit_q |-> ones_q == idle_n)
    else $error("idle pulse without a full run of ones");
  AST_MSB_STOP: assert property (msb_q |-> st_q == RX_STOP)
    else $error("address mark outside the last data bit");
endmodule
`default_nettype wire

// ===== hdl/urw_rx_if.sv
// urw_rx_if: receive engine to controller signals
// assumes both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
interface urw_rx_if;
  logic       line;
  logic       en;
  logic       long_frame;
  logic       idle_type;
  logic       done;
  logic [8:0] data;
  logic       msb_mark;
  logic       idle_lvl;
  logic       idle_hit;
  modport eng (input line, en, long_frame, idle_type,
               output done, data, msb_mark, idle_lvl, idle_hit);
  modport ctl (output line, en, long_frame, idle_type,
               input done, data, msb_mark, idle_lvl, idle_hit);
endinterface
`default_nettype wire

// ===== hdl/urw_top.sv
// urw_top: serial port receiver standby and wakeup, loop routing and irq flags
// assumes an APB master on pclk; rxd and txd_i are asynchronous pins
// Behaviour
// - standby suppresses receiver irqs; data still loads, rx full not set
// - wake select 0 means idle line wakeup, 1 means address mark wakeup
// - idle line wakeup: idle on the receive input clears standby
// - the waking idle character sets neither idle flag nor rx full
// - idle type picks counting ones after start bit or after stop bit
// - address mark wakeup: msb of 1 marks an address frame, clears standby
// - address frame clears standby before stop bit, then sets rx full
// - setting standby on an already idle line may wake at once
// - loop plus source 1: rx pin cut, receiver hears tx pin driver
// - single wire: direction bit 0 makes tx pin input, 1 output
// - loop plus source 0: rx pin cut, transmitter feeds receiver internally
// - all irq conditions ORed onto one active-high request line
// - sources: tx empty, tx complete, rx full with overrun, idle; own enables
// - tx empty set on shifter load; cleared by status read then data write
// - tx complete set when empty and idle; tx pin then idles high
// - tx complete cleared by status read then data write, or when queued
// - rx full set on data transfer; cleared by status read then data read
// - overrun when frame ends unread; new data dropped, held data kept
// - idle flag after 10 or 11 ones; rearms only after rx full
// - irq keeps working while the processor waits
`timescale 1ns/1ps
`default_nettype none
module urw_top
  import urw_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_DEF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // serial pins
  input  wire logic        rxd,
  input  wire logic        txd_i,
  output var  logic        txd_o,
  output var  logic        txd_oe,
  // interrupt
  output var  logic        irq
);
  localparam int unsigned CW = $clog2(BIT_CYC);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);

  urw_rx_if rx ();

  logic [1:0]    s1_q, s2_q, s3_q, pin_q;
  logic [4:0]    c1_q;
  logic [6:0]    c2_q;
  logic          dir_q;
  logic          tx_empty_flag_q, tc_q, rxf_q, idle_q, or_q;
  logic [4:0]    arm_q;
  logic          idle_ok_q;
  logic [8:0]    rdat_q, tdat_q;
  logic          tpend_q, busy_q;
  logic [10:0]   tsh_q;
  logic [3:0]    tcnt_q;
  logic [CW-1:0] ttmr_q;

  // apb decode; writes need the low byte lane
  wire setup  = psel & ~penable;
  wire xfer   = psel & penable & pready;
  wire wr     = xfer & pwrite & pstrb[0];
  wire rd     = xfer & ~pwrite;
  wire hit_c1 = paddr == A_CTRL1;
  wire hit_c2 = paddr == A_CTRL2;
  wire hit_s1 = paddr == A_STAT1;
  wire hit_s2 = paddr == A_STAT2;
  wire hit_d  = paddr == A_DATA;
  wire mapped = hit_c1 | hit_c2 | hit_s1 | hit_s2 | hit_d;
  wire c2_wr  = wr & hit_c2;
  wire d_wr   = wr & hit_d;
  wire d_rd   = rd & hit_d;
  wire [4:0]  flags = {tx_empty_flag_q, tc_q, rxf_q, idle_q, or_q};
  wire [31:0] rmux  = hit_c1 ? {27'h0, c1_q} :
                      hit_c2 ? {25'h0, c2_q} :
                      hit_s1 ? {24'h0, flags, 3'h0} :
                      hit_s2 ? {30'h0, dir_q, 1'b0} :
                      hit_d  ? {23'h0, rdat_q} : 32'h0;

  // a flag is armed only if software saw it set in the status read
  wire clr_tx_empty_flag = d_wr & arm_q[4];
  wire clr_tc   = d_wr & arm_q[3];
  wire clr_rx   = d_rd & arm_q[2];
  wire clr_idle = d_rd & arm_q[1];
  wire clr_or   = d_rd & arm_q[0];

  wire loop   = c1_q[C1_LOOP];
  wire single = loop & c1_q[C1_RX_SOURCE_SEL];
  wire wake   = c1_q[C1_WAKE];
  wire stby   = c2_q[C2_STBY];
  wire txen   = c2_q[C2_TXEN];

  // pin filter: a change counts once stages two and three agree
  wire [1:0] pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));

  // receive source routing
  assign rx.line = !loop ? pin_q[0] :
                   c1_q[C1_RX_SOURCE_SEL] ? pin_q[1] :
                   txd_o;
  assign rx.en         = c2_q[C2_RXEN];
  assign rx.long_frame = c1_q[C1_LONG];
  assign rx.idle_type  = c1_q[C1_ILT];

  // idle_lvl is a level, so standby set on an idle line wakes at once
  wire idle_wake = ~wake & rx.idle_lvl;
  wire addr_wake = wake & rx.msb_mark;
  wire stby_clr  = stby & (idle_wake | addr_wake);
  wire frame_ok  = rx.done & ~stby;
  wire rxf_set   = frame_ok & ~rxf_q;
  wire or_set    = frame_ok & rxf_q;
  wire idle_set  = rx.idle_hit & ~stby & idle_ok_q;
  wire rload     = rx.done & ~or_set;

  // transmitter
  wire load   = ~busy_q & tpend_q & txen;
  wire ttick  = ttmr_q == BIT_LAST;
  wire quiet  = tx_empty_flag_q & ~tpend_q & ~busy_q;
  wire txbit  = busy_q ? tsh_q[0] : 1'b1;
  wire [10:0] frame = c1_q[C1_LONG] ? {1'b1, tdat_q, 1'b0} :
                                     {2'h3, tdat_q[7:0], 1'b0};
  wire [3:0]  flen  = c1_q[C1_LONG] ? IDLE_LONG : IDLE_SHORT;

  wire irq_d = (tx_empty_flag_q & c2_q[C2_TIE]) | (tc_q & c2_q[C2_TX_COMPLETE_IRQ_EN]) |
               (~stby & ((c2_q[C2_RIE] & (rxf_q | or_q)) |
                         (c2_q[C2_IDLE_IRQ_EN] & idle_q)));

  urw_rx_eng #(
    .BIT_CYC (BIT_CYC)
  ) u_eng (
    .pclk    (pclk),
    .presetn (presetn),
    .rx      (rx.eng)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
      pin_q <= 2'h3;
    end else begin
      s1_q <= {txd_i, rxd};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  // zero wait states: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? rmux : 32'h0;
    end
  end

  // software write to standby wins over a wakeup in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= CTRL1_RST;
      c2_q <= CTRL2_RST;
      dir_q <= 1'b0;
    end else begin
      if (wr && hit_c1) begin
        c1_q <= pwdata[4:0];
      end
      if (wr && hit_s2) begin
        dir_q <= pwdata[S2_DIR];
      end
      if (c2_wr) begin
        c2_q <= pwdata[6:0];
      end else if (stby_clr) begin
        c2_q[C2_STBY] <= 1'b0;
      end
    end
  end

  // flags: a set in the cycle of its clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_flag_q <= TX_EMPTY_FLAG_RST;
      tc_q <= TC_RST;
      rxf_q <= 1'b0;
      idle_q <= 1'b0;
      or_q <= 1'b0;
      idle_ok_q <= 1'b1;
      arm_q <= 5'h00;
      rdat_q <= 9'h000;
    end else begin
      tx_empty_flag_q <= load | (tx_empty_flag_q & ~clr_tx_empty_flag);
      tc_q <= quiet | (tc_q & ~clr_tc & ~tpend_q);
      rxf_q <= rxf_set | (rxf_q & ~clr_rx);
      or_q <= or_set | (or_q & ~clr_or);
      idle_q <= idle_set | (idle_q & ~clr_idle);
      idle_ok_q <= rxf_set | (idle_ok_q & ~idle_set);
      if (rd && hit_s1) begin
        arm_q <= prdata[S1_LSB +: 5];
      end else if (d_wr || d_rd) begin
        arm_q <= 5'h00;
      end
      if (rload) begin
        rdat_q <= rx.data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdat_q <= 9'h000;
      tpend_q <= 1'b0;
      busy_q <= 1'b0;
      tsh_q <= 11'h7FF;
      tcnt_q <= 4'h0;
      ttmr_q <= '0;
    end else begin
      ttmr_q <= (load || ttick) ? '0 : ttmr_q + 1'b1;
      if (d_wr) begin
        tdat_q <= pwdata[8:0];
        tpend_q <= 1'b1;
      end else if (load) begin
        tpend_q <= 1'b0;
      end
      if (load) begin
        tsh_q <= frame;
        tcnt_q <= flen;
        busy_q <= 1'b1;
      end else if (busy_q && ttick) begin
        tsh_q <= {1'b1, tsh_q[10:1]};
        tcnt_q <= tcnt_q - 4'h1;
        busy_q <= tcnt_q != 4'h1;
      end
    end
  end

  // the request stays live in wait mode: no clock gating here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      txd_o <= 1'b1;
      txd_oe <= 1'b0;
    end else begin
      irq <= irq_d;
      txd_o <= txbit;
      txd_oe <= single ? dir_q : txen;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_STBY_KEEPS: assert property (stby && rx.done && !clr_rx |=> rxf_q == $past(rxf_q))
    else $error("rx full changed on a frame in standby");
  AST_IDLE_WAKE: assert property (stby && idle_wake && !c2_wr |=> !stby)
    else $error("idle line did not end standby");
  AST_WAKE_QUIET: assert property (stby && rx.idle_hit |=> !$rose(idle_q))
    else $error("waking idle set the idle flag");
  AST_ADDR_WAKE: assert property (stby && addr_wake && !c2_wr |=> !stby)
    else $error("address frame did not end standby");
  AST_ADDR_FULL: assert property (!stby && rx.done && !rxf_q |=> rxf_q)
    else $error("completed frame did not set rx full");
  AST_OVERRUN: assert property (frame_ok && rxf_q |=> or_q && rdat_q == $past(rdat_q))
    else $error("overrun lost held data or flag");
  AST_LOOP: assert property (loop && !c1_q[C1_RX_SOURCE_SEL] |-> rx.line == txd_o)
    else $error("internal loop not routed");
  AST_SINGLE: assert property (single |-> rx.line == pin_q[1])
    else $error("single wire not routed from tx pin");
  AST_DIR: assert property (single && $stable(c1_q) && $stable(dir_q) |-> txd_oe == dir_q)
    else $error("tx pin direction wrong");
  AST_TC_HIGH: assert property (tc_q |-> txd_o)
    else $error("tx pin low while complete");
  AST_TC_QUEUE: assert property (tpend_q && tc_q && !quiet |=> !tc_q)
    else $error("queued data left tx complete set");
  AST_TX_EMPTY_FLAG_LOAD: assert property (load |=> tx_empty_flag_q && busy_q ##1 !txd_o)
    else $error("load did not set tx empty or start bit");
  AST_IRQ_TX: assert property (tx_empty_flag_q && c2_q[C2_TIE] |=> irq)
    else $error("enabled tx empty gave no irq");
  AST_IRQ_MASK: assert property (stby && !(tx_empty_flag_q && c2_q[C2_TIE]) && !(tc_q && c2_q[C2_TX_COMPLETE_IRQ_EN])
                                 |=> !irq)
    else $error("receiver irq in standby");
  AST_IDLE_ARM: assert property ($rose(idle_q) |-> $past(idle_ok_q))
    else $error("idle flag set without rearm");

  COV_IDLE_WAKE: cover property (stby && idle_wake);
  COV_ADDR_WAKE: cover property (stby && addr_wake ##[1:400] rxf_set);
  COV_OVERRUN: cover property (or_set);
  COV_SINGLE_RX: cover property (single && rx.done);
endmodule
`default_nettype wire

// ===== verif/urw_link_model.sv
// urw_link_model: remote serial sender on a multi-drop receive line
// assumes the line has a pull-up, so it rests high between frames
`timescale 1ns/1ps
`default_nettype none
module urw_link_model #(
  parameter int unsigned BIT_CYC = 8
) (
  // clock
  input  wire logic pclk,
  // line
  output var  logic rxd
);
  initial rxd = 1'b1;

  // one frame: start, data lsb first, stop plus extra stop cycles for a slow sender
  task automatic send(input logic [8:0] d, input int nbits, input int slow);
    int i;
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (i = 0; i < nbits; i++) begin
      rxd <= d[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (BIT_CYC + slow) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== verif/urw_top_tb.sv
// urw_top_tb: self-checking bench for the serial port wakeup, loop and irq block
// assumes the design answers apb with pready and shortens bit time to BC cycles
`timescale 1ns/1ps
`default_nettype none
module urw_top_tb;
  import urw_pkg::*;
  localparam int unsigned BC = 8;
  localparam logic [31:0] ORN = 32'h08;
  localparam logic [31:0] IDL = 32'h10;
  localparam logic [31:0] RXF = 32'h20;
  localparam logic [31:0] TXC = 32'h40;
  localparam logic [31:0] TXE = 32'h80;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, b, c, got;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        pready, pslverr, rxd, txd_o, txd_oe, irq, e;
  wire logic   txd_i = txd_oe ? txd_o : 1'b1;
  int          n_errors, comparisons, seed, k;
  logic [31:0] ens [4] = '{32'h40, 32'h20, 32'h10, 32'h00};
  logic        exps [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  urw_top #(.BIT_CYC(BC)) urw_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd_i(txd_i),
    .txd_o(txd_o), .txd_oe(txd_oe), .irq(irq));
  urw_link_model #(.BIT_CYC(BC)) urw_link_model_inst (.pclk(pclk), .rxd(rxd));

  always #12.5 pclk = ~pclk;

  task automatic end_sim();
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    comparisons++;
    if (y !== x) begin
      $display("ERROR %s expected %h seen %h", nm, x, y);
      n_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      chk("pready", 1, 0);
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        er;
    apb(1'b1, a, d, r, er);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        er;
    apb(1'b0, a, 32'h0, r, er);
    chk("read", x, r & m);
  endtask

  task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        er;
    int          i;
    for (i = 0; i < 300; i++) begin
      apb(1'b0, a, 32'h0, r, er);
      if ((r & m) === x) return;
    end
    chk("wait", x, r & m);
    end_sim();
  endtask

  task automatic cap_tx(output logic [7:0] v);
    int i;
    for (i = 0; i < 200 && txd_o !== 1'b0; i++) @(posedge pclk);
    repeat (BC / 2) @(posedge pclk);
    for (i = 0; i < 8; i++) begin
      repeat (BC) @(posedge pclk);
      v[i] = txd_o;
    end
  endtask

  // loop and single-wire: tx byte must come back while the rx pin carries another
  task automatic echo();
    b = 8'($random(seed));
    c = ~b;
    fork
      wr(A_DATA, {24'h0, b});
      urw_link_model_inst.send({1'b0, c}, 8, 0);
    join
    wait_reg(A_STAT1, RXF, RXF);
    rdc(A_DATA, 32'h1FF, {24'h0, b});
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    n_errors = 0;
    comparisons = 0;
    seed = 94;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(A_CTRL2, 32'h7F, 32'h0);
    rdc(A_STAT1, 32'hF8, TXE | TXC);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk("slverr", 1, e);
    chk("irq", 0, irq);
    // plain receive, then idle flag and its rearm
    wr(A_CTRL2, 32'h12);
    b = 8'($random(seed));
    urw_link_model_inst.send({1'b0, b}, 8, 3);
    wait_reg(A_STAT1, RXF, RXF);
    chk("irq", 1, irq);
    rdc(A_DATA, 32'h1FF, {24'h0, b});
    rdc(A_STAT1, RXF, 0);
    wait_reg(A_STAT1, IDL, IDL);
    rdc(A_DATA, 32'h1FF, {24'h0, b});
    repeat (30 * BC) @(posedge pclk);
    rdc(A_STAT1, IDL, 0);
    // two frames of one message back to back, none read
    b = 8'($random(seed));
    c = 8'($random(seed));
    urw_link_model_inst.send({1'b0, b}, 8, 0);
    urw_link_model_inst.send({1'b0, c}, 8, 0);
    wait_reg(A_STAT1, ORN | RXF, ORN | RXF);
    rdc(A_DATA, 32'h1FF, {24'h0, b});
    rdc(A_STAT1, ORN | RXF, 0);
    // address mark wakeup
    wr(A_CTRL1, 32'h04);
    wr(A_CTRL2, 32'h13);
    b = 8'($random(seed)) & 8'h7F;
    urw_link_model_inst.send({1'b0, b}, 8, 0);
    repeat (2 * BC) @(posedge pclk);
    rdc(A_STAT1, RXF, 0);
    chk("irq", 0, irq);
    rdc(A_CTRL2, 32'h7F, 32'h13);
    rdc(A_DATA, 32'h1FF, {24'h0, b});
    c = 8'($random(seed)) | 8'h80;
    urw_link_model_inst.send({1'b0, c}, 8, 0);
    wait_reg(A_STAT1, RXF, RXF);
    rdc(A_CTRL2, 32'h7F, 32'h12);
    rdc(A_DATA, 32'h1FF, {24'h0, c});
    wait_reg(A_STAT1, IDL, IDL);
    rdc(A_DATA, 32'h1FF, {24'h0, c});
    // idle line wakeup: the waking idle sets no idle flag
    wr(A_CTRL1, 32'h00);
    urw_link_model_inst.send(9'h000, 8, 0);
    wr(A_CTRL2, 32'h13);
    wait_reg(A_CTRL2, 32'h01, 32'h0);
    rdc(A_STAT1, IDL, 0);
    wr(A_CTRL2, 32'h13);
    wait_reg(A_CTRL2, 32'h01, 32'h0);
    rdc(A_STAT1, RXF, RXF);
    rdc(A_DATA, 32'h1FF, 32'h0);
    // transmit: flags and frame on the pin
    wr(A_CTRL2, 32'h04);
    repeat (2) @(posedge pclk);
    chk("txd_oe", 1, txd_oe);
    chk("txd_o", 1, txd_o);
    rdc(A_STAT1, TXE | TXC, TXE | TXC);
    b = 8'($random(seed));
    wr(A_DATA, {24'h0, b});
    fork
      cap_tx(got);
      begin
        repeat (6) @(posedge pclk);
        rdc(A_STAT1, TXE | TXC, TXE);
      end
    join
    chk("tx byte", b, got);
    wait_reg(A_STAT1, TXC, TXC);
    chk("txd_o", 1, txd_o);
    for (k = 0; k < 4; k++) begin
      wr(A_CTRL2, 32'h04 | ens[k]);
      repeat (2) @(posedge pclk);
      chk("irq", exps[k], irq);
    end
    // internal loop, then single wire
    wr(A_CTRL1, 32'h10);
    wr(A_CTRL2, 32'h06);
    echo();
    wr(A_CTRL1, 32'h18);
    wr(A_STAT2, 32'h02);
    repeat (2) @(posedge pclk);
    chk("txd_oe", 1, txd_oe);
    echo();
    wr(A_STAT2, 32'h00);
    repeat (2) @(posedge pclk);
    chk("txd_oe", 0, txd_oe);
    end_sim();
  end
endmodule
`default_nettype wire
